/* logic/spf_top.sv */
// serial memory front end: selection, opcode, address, mode, wait and data framing
// assumes a command decoder answers the opcode with a descriptor on the CMD_ ports
// in the same cycle as OPC_VALID_O, and a memory core feeds RD_DATA_I
`timescale 1ns/1ps
`default_nettype none
module spf_top import spf_pkg::*; (
    input  wire logic             CLK_SYS_I,
    input  wire logic             RST_I,
    input  wire logic             SCK_I,
    input  wire logic             CS_N_I,
    input  wire logic [3:0]       IO_I,
    output logic      [3:0]       IO_O,
    output logic      [3:0]       IO_OE_O,
    input  wire logic [1:0]       INTERFACE_CFG_I,
    input  wire logic [LAT_W-1:0] MEM_LAT_CFG_I,
    input  wire logic [LAT_W-1:0] REG_LAT_CFG_I,
    input  wire logic             CMD_ADDR_I,
    input  wire logic             CMD_MODE_I,
    input  wire logic             CMD_MODE_FULL_I,
    input  wire logic             CMD_READ_I,
    input  wire logic             CMD_WRITE_I,
    input  wire logic             CMD_REG_I,
    input  wire logic             CMD_DDR_I,
    input  wire logic [2:0]       CMD_ALANES_I,
    input  wire logic [2:0]       CMD_DLANES_I,
    input  wire logic [7:0]       RD_DATA_I,
    output logic      [7:0]       OPCODE_O,
    output logic                  OPC_VALID_O,
    output logic      [18:0]      ADDR_O,
    output logic                  ADDR_VALID_O,
    output logic      [7:0]       WR_DATA_O,
    output logic                  WR_VALID_O,
    output logic                  RD_REQ_O,
    output logic                  IN_PLACE_EXEC_O,
    output logic                  MODE3_O,
    output logic                  SELECTED_O
);
    spf_smp_if smp ();

    spf_sampler u_smp (
        .clk_i  (CLK_SYS_I),
        .rst_i  (RST_I),
        .sck_i  (SCK_I),
        .cs_n_i (CS_N_I),
        .io_i   (IO_I),
        .smp    (smp.src)
    );

    spf_state_t       state_q;
    logic [4:0]       cnt_q;
    logic [23:0]      sh_q;
    logic             d_addr_q;
    logic             d_mode_q;
    logic             d_full_q;
    logic             d_read_q;
    logic             d_write_q;
    logic             d_ddr_q;
    logic [2:0]       d_alanes_q;
    logic [2:0]       d_dlanes_q;
    logic [LAT_W-1:0] d_lat_q;
    logic             in_place_q;
    logic [7:0]       out_sh_q;
    logic [2:0]       out_cnt_q;
    logic             started_q;
    logic [2:0]       ph_lanes;
    logic [4:0]       ph_bits;
    logic             in_ddr;
    logic             take_in;
    logic [4:0]       cnt_nx;
    logic [23:0]      sh_nx;
    logic             ph_done;
    logic             drive;
    logic             ddr_in_mode3;
    logic [LAT_W-1:0] lat_cmd;

    // lanes and length of the phase being received
    always_comb begin
        ph_lanes = LN1;
        ph_bits  = BYTE_BITS;
        unique case (state_q)
            ST_OPC:  ph_lanes = spf_if_lanes(INTERFACE_CFG_I);
            ST_ADDR: begin
                ph_lanes = d_alanes_q;
                ph_bits  = ADDR_BITS;
            end
            ST_MODE: ph_lanes = d_alanes_q;
            ST_DATA: ph_lanes = d_dlanes_q;
            default: ph_lanes = LN1;
        endcase
    end

    // opcode always rises-only; address, mode and data phases of a double-rate command use both edges, wait cycles only rises
    // the fall that ends the last opcode bit must not count as the first address bit
    assign in_ddr  = d_ddr_q && (state_q inside {ST_ADDR, ST_MODE, ST_DATA})
                     && !(state_q == ST_ADDR && cnt_q == 5'h00);
    assign take_in = !smp.cs_n && (smp.sck_rise || (in_ddr && smp.sck_fall))
                     && ((state_q inside {ST_OPC, ST_ADDR, ST_MODE})
                         || (state_q == ST_DATA && d_write_q));
    assign cnt_nx  = cnt_q + {2'b00, ph_lanes};
    assign sh_nx   = spf_shift(sh_q, smp.io, ph_lanes);
    assign ph_done = take_in && (cnt_nx == ph_bits);
    assign lat_cmd = CMD_REG_I ? REG_LAT_CFG_I : MEM_LAT_CFG_I;
    // a double-rate command seen while the clock idled high is refused
    assign ddr_in_mode3 = CMD_DDR_I && MODE3_O;

    // frame sequencing; a deselect at any point drops the instruction
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I || smp.cs_n) begin
            state_q <= ST_IDLE;
            cnt_q   <= 5'h00;
            sh_q    <= 24'h00_0000;
        end else if (smp.cs_fall) begin
            cnt_q <= 5'h00;
            if (!in_place_q)
                state_q <= ST_OPC;
            else if (d_ddr_q && smp.sck)
                state_q <= ST_DONE;
            else
                state_q <= ST_ADDR;
        end else begin
            if (take_in) begin
                cnt_q <= ph_done ? 5'h00 : cnt_nx;
                sh_q  <= sh_nx;
            end
            unique case (state_q)
                ST_OPC: begin
                    if (ph_done)
                        state_q <= ST_DECODE;
                end
                ST_DECODE: begin
                    if (ddr_in_mode3)
                        state_q <= ST_DONE;
                    else if (CMD_ADDR_I)
                        state_q <= ST_ADDR;
                    else if (CMD_MODE_I)
                        state_q <= ST_MODE;
                    else
                        state_q <= spf_after_mode(CMD_READ_I, CMD_WRITE_I, lat_cmd);
                end
                ST_ADDR: begin
                    if (ph_done)
                        state_q <= d_mode_q ? ST_MODE
                                            : spf_after_mode(d_read_q, d_write_q, d_lat_q);
                end
                ST_MODE: begin
                    if (ph_done)
                        state_q <= spf_after_mode(d_read_q, d_write_q, d_lat_q);
                end
                ST_DUMMY: begin
                    // a wait cycle is a whole clock period, counted on rising edges
                    if (smp.sck_rise) begin
                        if ({1'b0, d_lat_q} == cnt_q + 5'h01) begin
                            state_q <= ST_DATA;
                            cnt_q   <= 5'h00;
                        end else begin
                            cnt_q <= cnt_q + 5'h01;
                        end
                    end
                end
                default: state_q <= state_q;
            endcase
        end
    end

    // command descriptor, kept across frames so an armed frame can repeat it
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            d_addr_q   <= 1'b0;
            d_mode_q   <= 1'b0;
            d_full_q   <= 1'b0;
            d_read_q   <= 1'b0;
            d_write_q  <= 1'b0;
            d_ddr_q    <= 1'b0;
            d_alanes_q <= LN1;
            d_dlanes_q <= LN1;
            d_lat_q    <= 4'h0;
        end else if (state_q == ST_DECODE && !smp.cs_n) begin
            d_addr_q   <= CMD_ADDR_I;
            d_mode_q   <= CMD_MODE_I;
            d_full_q   <= CMD_MODE_FULL_I;
            d_read_q   <= CMD_READ_I;
            d_write_q  <= CMD_WRITE_I;
            d_ddr_q    <= CMD_DDR_I;
            d_alanes_q <= CMD_ALANES_I;
            d_dlanes_q <= CMD_DLANES_I;
            d_lat_q    <= lat_cmd;
        end
    end

    // in-place execution: dropped at every frame start, re-armed only by a keep byte
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            in_place_q <= 1'b0;
        end else if (state_q == ST_MODE && ph_done) begin
            in_place_q <= d_mode_q && spf_mode_keeps(sh_nx[7:0], d_full_q);
        end else if (smp.cs_fall) begin
            in_place_q <= 1'b0;
        end
    end
    assign IN_PLACE_EXEC_O = in_place_q;

    // clock mode taken from the clock level as the device is selected
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I)
            MODE3_O <= 1'b0;
        else if (smp.cs_fall)
            MODE3_O <= smp.sck;
    end

    // edges before selection never count; in mode 3 the first edge seen is a fall
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I)
            SELECTED_O <= 1'b0;
        else
            SELECTED_O <= !smp.cs_n;
    end

    // reports to the command decoder and memory core
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            OPCODE_O     <= 8'h00;
            OPC_VALID_O  <= 1'b0;
            ADDR_O       <= 19'h0_0000;
            ADDR_VALID_O <= 1'b0;
            WR_DATA_O    <= 8'h00;
            WR_VALID_O   <= 1'b0;
        end else begin
            OPC_VALID_O  <= state_q == ST_OPC && ph_done;
            ADDR_VALID_O <= state_q == ST_ADDR && ph_done;
            WR_VALID_O   <= state_q == ST_DATA && ph_done;
            if (state_q == ST_OPC && ph_done)
                OPCODE_O <= sh_nx[7:0];
            if (state_q == ST_ADDR && ph_done)
                ADDR_O <= sh_nx[ADDR_USED-1:0];
            if (state_q == ST_DATA && ph_done)
                WR_DATA_O <= sh_nx[7:0];
        end
    end

    // read drive: first bit on a falling edge, then every edge for double rate
    assign drive = state_q == ST_DATA && d_read_q && !smp.cs_n
                   && (smp.sck_fall || (d_ddr_q && started_q && smp.sck_rise));

    // output lanes released whenever the frame leaves the read data phase
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I || smp.cs_n || state_q != ST_DATA) begin
            IO_O      <= 4'h0;
            IO_OE_O   <= OE_OFF;
            out_sh_q  <= 8'h00;
            out_cnt_q <= 3'h0;
            started_q <= 1'b0;
            RD_REQ_O  <= 1'b0;
        end else begin
            RD_REQ_O <= 1'b0;
            if (drive) begin
                started_q <= 1'b1;
                IO_OE_O   <= spf_oe(d_dlanes_q);
                out_cnt_q <= out_cnt_q + d_dlanes_q;
                if (out_cnt_q == 3'h0) begin
                    // the core has the next byte ready well before it is needed
                    IO_O     <= spf_out_bits(RD_DATA_I, d_dlanes_q);
                    out_sh_q <= RD_DATA_I << d_dlanes_q;
                    RD_REQ_O <= 1'b1;
                end else begin
                    IO_O     <= spf_out_bits(out_sh_q, d_dlanes_q);
                    out_sh_q <= out_sh_q << d_dlanes_q;
                end
            end
        end
    end

    // checking helpers
    logic opc_seen_q;
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I || smp.cs_fall)
            opc_seen_q <= 1'b0;
        else if (OPC_VALID_O)
            opc_seen_q <= 1'b1;
    end

    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);

    sequence seq_mode_keep;
        state_q == ST_MODE && ph_done && spf_mode_keeps(sh_nx[7:0], d_full_q);
    endsequence
    sequence seq_mode_other;
        state_q == ST_MODE && ph_done && !spf_mode_keeps(sh_nx[7:0], d_full_q);
    endsequence
    sequence seq_armed_start;
        smp.cs_fall && in_place_q && !(d_ddr_q && smp.sck);
    endsequence
    sequence seq_held_select;
        smp.cs_fall ##1 (!smp.cs_n)[*3];
    endsequence

    AST_DESELECT_QUIET: assert property (
        smp.cs_n && $past(smp.cs_n) |-> IO_OE_O == OE_OFF && !WR_VALID_O && !ADDR_VALID_O)
        else $error("pins driven or data reported while deselected");
    AST_ONE_OPCODE: assert property (
        OPC_VALID_O |-> !opc_seen_q)
        else $error("second opcode in one selection");
    AST_OPC_FIRST: assert property (
        OPC_VALID_O |-> $past(state_q) == ST_OPC && OPCODE_O == sh_q[7:0])
        else $error("opcode reported outside the first byte");
    AST_SDR_FALL_DRIVE: assert property (
        state_q == ST_DATA && $past(state_q) == ST_DATA && !d_ddr_q && $changed(IO_O)
        |-> $past(smp.sck_fall))
        else $error("single-rate output changed off a falling edge");
    AST_ADDR_LOW: assert property (
        ADDR_VALID_O |-> $past(state_q) == ST_ADDR && ADDR_O == sh_q[18:0])
        else $error("address not the low nineteen received bits");
    AST_INPLACE_SKIP: assert property (
        seq_armed_start |=> state_q == ST_ADDR ##1 !OPC_VALID_O)
        else $error("armed frame did not start at the address");
    AST_INPLACE_ARM: assert property (
        seq_mode_keep |=> in_place_q [*2])
        else $error("keep byte did not arm in-place execution");
    AST_INPLACE_DROP: assert property (
        seq_mode_other |=> !in_place_q)
        else $error("other mode byte left in-place execution armed");
    AST_MODE_SENSE: assert property (
        seq_held_select |-> MODE3_O == $past(smp.sck, 3))
        else $error("clock mode not taken from clock level at selection");
    AST_DDR_MODE0: assert property (
        state_q == ST_DATA && d_ddr_q |-> !MODE3_O)
        else $error("double-rate data phase in clock mode 3");
    AST_WAIT_COUNT: assert property (
        state_q == ST_DATA && $past(state_q) == ST_DUMMY
        |-> $past(smp.sck_rise) && {1'b0, d_lat_q} == $past(cnt_q) + 5'h01)
        else $error("read data began before the wait count elapsed");
    AST_DDR_FIRST_RISE: assert property (
        state_q == ST_ADDR && cnt_q == 5'h00 && take_in |-> smp.sck_rise)
        else $error("address phase began on a falling clock edge");
    AST_WAIT_IGNORED: assert property (
        state_q == ST_DUMMY && $past(state_q) == ST_DUMMY |-> $stable(sh_q))
        else $error("pin levels taken during a wait cycle");
    AST_DRIVE_LANES: assert property (
        IO_OE_O != OE_OFF |-> state_q == ST_DATA && d_read_q && IO_OE_O == spf_oe(d_dlanes_q))
        else $error("pins driven outside a read data phase or on wrong lanes");
    AST_DESELECT_REVERT: assert property (
        smp.cs_n |=> IO_OE_O == OE_OFF && state_q == ST_IDLE)
        else $error("deselect left the pins driven or the frame running");
    AST_DDR_REFUSED: assert property (
        state_q == ST_DECODE && !smp.cs_n && CMD_DDR_I && MODE3_O |=> state_q == ST_DONE)
        else $error("double-rate command accepted in clock mode 3");
endmodule
`default_nettype wire

/* logic/spf_pkg.sv */
// constants, types and helpers for the serial framing front end
// assumes one system clock; link pins are sampled, never used as clocks
`default_nettype none
package spf_pkg;
    localparam logic [4:0] OPC_BITS   = 5'h18 - 5'h10;  // 8
    localparam logic [4:0] ADDR_BITS  = 5'h18;          // 24
    localparam int         ADDR_USED  = 19;
    localparam logic [4:0] BYTE_BITS  = 5'h08;
    localparam logic [7:0] MODE_MASK  = 8'hF0;
    localparam logic [7:0] MODE_NIB   = 8'hA0;
    localparam logic [7:0] MODE_FULL  = 8'hA5;
    localparam int         LAT_W      = 4;
    localparam logic [1:0] IFC_SPI    = 2'h0;
    localparam logic [1:0] IFC_DPI    = 2'h1;
    localparam logic [1:0] IFC_QPI    = 2'h2;
    localparam logic [2:0] LN1        = 3'h1;
    localparam logic [2:0] LN2        = 3'h2;
    localparam logic [2:0] LN4        = 3'h4;
    localparam logic [3:0] OE_OFF     = 4'h0;
    localparam logic [5:0] SMP_RST    = 6'h20;          // {cs_n, sck, io[3:0]}

    typedef enum logic [2:0] {
        ST_IDLE, ST_OPC, ST_DECODE, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA, ST_DONE
    } spf_state_t;

    // lanes used by the opcode for the configured interface
    function automatic logic [2:0] spf_if_lanes(input logic [1:0] cfg);
        unique case (cfg)
            IFC_DPI: return LN2;
            IFC_QPI: return LN4;
            default: return LN1;
        endcase
    endfunction

    // shift new bits in below the older ones, msb first
    function automatic logic [23:0] spf_shift(input logic [23:0] sh, input logic [3:0] io,
                                              input logic [2:0] lanes);
        unique case (lanes)
            LN2:     return {sh[21:0], io[1:0]};
            LN4:     return {sh[19:0], io};
            default: return {sh[22:0], io[0]};
        endcase
    endfunction

    // top bits of an outgoing byte placed on the lanes; single line uses pin 1
    function automatic logic [3:0] spf_out_bits(input logic [7:0] b, input logic [2:0] lanes);
        unique case (lanes)
            LN2:     return {2'b00, b[7:6]};
            LN4:     return b[7:4];
            default: return {2'b00, b[7], 1'b0};
        endcase
    endfunction

    function automatic logic [3:0] spf_oe(input logic [2:0] lanes);
        unique case (lanes)
            LN2:     return 4'h3;
            LN4:     return 4'hF;
            default: return 4'h2;
        endcase
    endfunction

    function automatic logic spf_mode_keeps(input logic [7:0] m, input logic full);
        return full ? (m == MODE_FULL) : ((m & MODE_MASK) == MODE_NIB);
    endfunction

    // phase that follows the address and mode bytes
    function automatic spf_state_t spf_after_mode(input logic rd, input logic wr,
                                                  input logic [3:0] lat);
        if (rd && lat != 4'h0)
            return ST_DUMMY;
        if (rd || wr)
            return ST_DATA;
        return ST_DONE;
    endfunction
endpackage
`default_nettype wire

/* logic/spf_smp_if.sv */
// sampled view of the link pins, handed from the sampler to the framer
// assumes both sides run on the system clock
`timescale 1ns/1ps
`default_nettype none
interface spf_smp_if;
    logic       sck;
    logic       sck_rise;
    logic       sck_fall;
    logic       cs_n;
    logic       cs_fall;
    logic [3:0] io;
    modport src (output sck, sck_rise, sck_fall, cs_n, cs_fall, io);
    modport dst (input  sck, sck_rise, sck_fall, cs_n, cs_fall, io);
endinterface
`default_nettype wire

/* logic/spf_sampler.sv */
// two-stage synchroniser and edge finder for the link pins
// assumes the system clock runs several times faster than the serial clock
`timescale 1ns/1ps
`default_nettype none
module spf_sampler import spf_pkg::*; (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       sck_i,
    input  wire logic       cs_n_i,
    input  wire logic [3:0] io_i,
    spf_smp_if.src          smp
);
    logic [5:0] m1_q;
    logic [5:0] m2_q;
    logic [5:0] m3_q;

    // pins travel together so data stays aligned with the clock edges seen
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            m1_q <= SMP_RST;
            m2_q <= SMP_RST;
            m3_q <= SMP_RST;
        end else begin
            m1_q <= {cs_n_i, sck_i, io_i};
            m2_q <= m1_q;
            m3_q <= m2_q;
        end
    end

    // edges come from the second and third stages only
    assign smp.sck      = m2_q[4];
    assign smp.sck_rise = m2_q[4] & ~m3_q[4];
    assign smp.sck_fall = ~m2_q[4] & m3_q[4];
    assign smp.cs_n     = m2_q[5];
    assign smp.cs_fall  = ~m2_q[5] & m3_q[5];
    assign smp.io       = m2_q[3:0];
endmodule
`default_nettype wire

/* bench/spf_host.sv */
// host-side serial master model: drives clock, select and data pins
// assumes the bench resolves the device output onto so_i
`timescale 1ns/1ps
`default_nettype none
module spf_host (
    output logic       sck_o,
    output logic       cs_n_o,
    output logic [3:0] io_o,
    input  wire logic  so_i
);
    // idle: deselected, clock low
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        io_o = 4'h5;
    end
    // select; clock level at the fall picks mode 0 or 3
    task automatic sel(input logic m3);
        #3 sck_o = m3;
        #32 cs_n_o = 1'b0;
        #32 sck_o = 1'b0;
    endtask
    // one byte msb first, sampled by the device on rises
    task automatic put(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            io_o = {3'b000, v[i]};
            #32 sck_o = 1'b1;
            #32 sck_o = 1'b0;
        end
    endtask
    // wait clocks; lines toggle so a stray sample would show
    task automatic wt(input int n);
        repeat (n) begin
            io_o = ~io_o;
            #32 sck_o = 1'b1;
            #32 sck_o = 1'b0;
        end
    endtask
    // read one byte, taken late in the high phase when settled
    task automatic get(output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            #32 sck_o = 1'b1;
            #30 b[i] = so_i;
            io_o = ~io_o;
            #2 sck_o = 1'b0;
        end
    endtask
    // deselect, clock back to its idle level first
    task automatic desel(input logic m3);
        #32 sck_o = m3;
        #32 cs_n_o = 1'b1;
        io_o = ~io_o;
        #128;
    endtask
endmodule
`default_nettype wire

/* bench/spf_slave_protocol_framing_tb_top.sv */
// bench: host model on the pins, queues of reported results per frame
// assumes single-line frames, descriptor held static across each frame
`timescale 1ns/1ps
`default_nettype none
module spf_slave_protocol_framing_tb_top import spf_pkg::*;;
    logic        clk, rst, sck, cs_n, md_c, fl_c, rd_c, wr_c, rg_c;
    logic        opv, adv, wrv, ipx, m3_o, sel_o;
    logic        ad_c, dd_c, rrq;
    logic [1:0]  ifc;
    int          n_req = 0;
    logic [3:0]  h_io, pin, d_io, d_oe, mlat, rlat;
    logic [7:0]  rdat, opc, wdat;
    logic [18:0] adr;
    logic [31:0] lfsr = 32'h0000_876d;
    int          miscompares = 0;
    int          n_checks = 0;
    logic [7:0]  q_op[$];
    logic [7:0]  q_wr[$];
    logic [18:0] q_ad[$];
    // wire level from every party's enable
    assign pin = (d_oe & d_io) | (~d_oe & h_io);
    spf_top i_dut (.CLK_SYS_I(clk), .RST_I(rst), .SCK_I(sck), .CS_N_I(cs_n), .IO_I(pin),
        .IO_O(d_io), .IO_OE_O(d_oe), .INTERFACE_CFG_I(ifc), .MEM_LAT_CFG_I(mlat),
        .REG_LAT_CFG_I(rlat), .CMD_ADDR_I(ad_c), .CMD_MODE_I(md_c), .CMD_MODE_FULL_I(fl_c),
        .CMD_READ_I(rd_c), .CMD_WRITE_I(wr_c), .CMD_REG_I(rg_c), .CMD_DDR_I(dd_c),
        .CMD_ALANES_I(LN1), .CMD_DLANES_I(LN1), .RD_DATA_I(rdat), .OPCODE_O(opc),
        .OPC_VALID_O(opv), .ADDR_O(adr), .ADDR_VALID_O(adv), .WR_DATA_O(wdat),
        .WR_VALID_O(wrv), .RD_REQ_O(rrq), .IN_PLACE_EXEC_O(ipx), .MODE3_O(m3_o),
        .SELECTED_O(sel_o));
    spf_host i_host (.sck_o(sck), .cs_n_o(cs_n), .io_o(h_io), .so_i(pin[1]));
    // 125 MHz system clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // collect every pulse mid-cycle, away from the edge that launches it
    always @(negedge clk) begin
        if (rrq === 1'b1) n_req++;
        if (opv === 1'b1) q_op.push_back(opc);
        if (adv === 1'b1) q_ad.push_back(adr);
        if (wrv === 1'b1) q_wr.push_back(wdat);
    end
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wrap_up;
        if (miscompares == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // random opcode and address, sent msb first; shared by read and write frames
    task automatic head(input logic op_ph, input logic m3, output logic [23:0] a);
        lfsr = nx(lfsr);
        // ignored top bits sent as zero in about half the frames, random otherwise
        a = {lfsr[23:19] & {5{lfsr[31]}}, lfsr[18:0]};
        i_host.sel(m3);
        chk("sel", 1, sel_o);
        chk("mode3", m3, m3_o);
        // the bench plays the decoder and answers every code, so none is reserved
        if (op_ph) i_host.put(lfsr[31:24]);
        i_host.put(a[23:16]);
        i_host.put(a[15:8]);
        i_host.put(a[7:0]);
        if (op_ph) chk("opc", lfsr[31:24], q_op.pop_front());
        else chk("no_opc", 0, 24'(q_op.size()));
        chk("addr", a[18:0], q_ad.pop_front());
    endtask
    task automatic rd(input logic m3, input logic rg);
        logic [23:0] a;
        logic [7:0]  got;
        @(posedge clk);
        #1 {rd_c, wr_c, md_c, fl_c, rg_c} = {4'b1000, rg};
        rdat = lfsr[7:0] ^ 8'h3C;
        n_req = 0;
        head(1'b1, m3, a);
        i_host.wt(rg ? 2 : 1);
        i_host.get(got);
        chk("oe_rd", 4'h2, d_oe);
        i_host.desel(m3);
        chk("rd_byte", rdat, got);
        chk("no_arm", 0, ipx);
        chk("oe_idle", OE_OFF, d_oe);
        chk("rd_req", 2, 24'(n_req));
    endtask
    task automatic wrf(input logic op_ph, input logic [7:0] md, input logic fl, input logic arm);
        logic [23:0] a;
        @(posedge clk);
        #1 {rd_c, wr_c, md_c, fl_c, rg_c} = {3'b011, fl, 1'b0};
        head(op_ph, 1'b0, a);
        i_host.put(md);
        i_host.put(a[15:8]);
        i_host.desel(1'b0);
        chk("wr_byte", a[15:8], q_wr.pop_front());
        chk("arm", arm, ipx);
    endtask
    // stop a hung run
    initial begin
        #400000;
        miscompares++;
        wrap_up();
    end
    initial begin
        rst = 1'b1;
        mlat = 4'h1;
        rlat = 4'h2;
        rdat = 8'h00;
        {rd_c, wr_c, md_c, fl_c, rg_c} = 5'h00;
        {ad_c, dd_c, ifc} = {2'b10, IFC_SPI};
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        chk("oe_rst", OE_OFF, d_oe);
        repeat (4) @(posedge clk);
        rd(1'b0, 1'b0);
        rd(1'b1, 1'b1);
        // keep byte arms, armed frame skips opcode, other byte disarms
        wrf(1'b1, 8'hA7, 1'b0, 1'b1);
        wrf(1'b0, 8'h3C, 1'b0, 1'b0);
        wrf(1'b1, 8'hA5, 1'b1, 1'b1);
        wrf(1'b0, 8'hA0, 1'b1, 1'b0);
        // last write disarms before the bench switches to other operations
        wrf(1'b1, 8'h00, 1'b0, 1'b0);
        // double-rate read in clock mode 3 is refused: no address despite three bytes
        @(posedge clk);
        #1 {dd_c, rd_c, wr_c, md_c} = 4'b1100;
        i_host.sel(1'b1);
        i_host.put(8'h5A);
        i_host.put(8'h12);
        i_host.put(8'h34);
        i_host.put(8'h56);
        i_host.wt(2);
        chk("ddr_m3_oe", OE_OFF, d_oe);
        i_host.desel(1'b1);
        chk("ddr_m3_opc", 8'h5A, q_op.pop_front());
        chk("ddr_m3_addr", 0, 24'(q_ad.size()));
        // opcode-only command on the spare interface code: opcode still on one line
        @(posedge clk);
        #1 {dd_c, ad_c, rd_c, ifc} = {3'b000, 2'h3};
        i_host.sel(1'b0);
        i_host.put(8'hC3);
        i_host.put(8'h77);
        i_host.put(8'h77);
        i_host.put(8'h77);
        i_host.desel(1'b0);
        chk("bare_opc", 8'hC3, q_op.pop_front());
        chk("bare_addr", 0, 24'(q_ad.size()));
        @(posedge clk);
        #1 {ad_c, ifc} = {1'b1, IFC_SPI};
        // abort after one address byte, then a full frame recovers
        i_host.sel(1'b0);
        i_host.put(8'h9B);
        i_host.put(8'h11);
        i_host.desel(1'b0);
        chk("abort_opc", 8'h9B, q_op.pop_front());
        chk("abort_addr", 0, 24'(q_ad.size()));
        rd(1'b0, 1'b0);
        wrap_up();
    end
endmodule
`default_nettype wire
